//--- hw/sfrb_pkg.sv
`default_nettype none
package sfrb_pkg;
    // register offsets
    localparam logic [7:0] ADDR_STAT_LOW = 8'h00;
    localparam logic [7:0] ADDR_STAT_HIGH = 8'h01;
    localparam logic [7:0] ADDR_CLR_LOW = 8'h02;
    localparam logic [7:0] ADDR_CLR_HIGH = 8'h03;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h04;
    localparam logic [7:0] ADDR_SYS_CTRL = 8'h05;
    localparam logic [7:0] ADDR_CONV_SETUP = 8'h19;
    // reset values
    localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] SYS_CTRL_RST = 8'h80;
    localparam logic [7:0] CONV_SETUP_RST = 8'h4B;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    // field positions
    localparam int SYS_CTRL_COR_BIT = 7;
    localparam int CUR_LIMIT_LSB = 0;
    localparam int CUR_LIMIT_W = 4;
    localparam int AUX_CLR_BIT = 0;
    // latched bits of each status register
    localparam logic [7:0] LOW_LATCH_MASK = 8'hFE;
    localparam logic [7:0] HIGH_LATCH_MASK = 8'h1A;
    // positions of the synchronised inputs
    localparam int IDX_LDO = 0;
    localparam int IDX_BROWNOUT = 8;
    localparam int IDX_OVERPOWER = 9;
    localparam int IDX_OVERVOLT = 10;
    localparam int IDX_AUX = 11;
    localparam int NUM_IN = 12;
    localparam int NUM_EVT = 11;
    // status high bit positions
    localparam int HIGH_BROWNOUT_BIT = 1;
    localparam int HIGH_OVERPOWER_BIT = 3;
    localparam int HIGH_OVERVOLT_BIT = 4;
    // timing
    localparam longint unsigned CLK_FREQ_HZ = 250_000_000;
    localparam longint unsigned DEBOUNCE_MS = 11;
    localparam longint unsigned DEBOUNCE_CYCLES = (DEBOUNCE_MS * CLK_FREQ_HZ + 64'd999) / 64'd1000;
    // link request payload: write flag, address, data
    localparam int REQ_W = 17;
    localparam int RSP_W = 8;
endpackage : sfrb_pkg
`default_nettype wire

//--- hw/sfrb_debounce.sv
`default_nettype none
module sfrb_debounce #(
    parameter int CYCLES = 2750000
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // level, already synchronised
    input wire logic din,
    output logic dout
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic level;
    } sfrb_deb_s;

    sfrb_deb_s q;
    sfrb_deb_s d;

    // a new level must hold for the full window; any bounce restarts it
    always_comb
    begin
        d = q;
        if (din == q.level)
        begin
            d.cnt = '0;
        end
        else if (q.cnt == LAST)
        begin
            d.cnt = '0;
            d.level = din;
        end
        else
        begin
            d.cnt = q.cnt + CW'(1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign dout = q.level;
endmodule : sfrb_debounce
`default_nettype wire

//--- hw/sfrb_cdc_req.sv
`default_nettype none
module sfrb_cdc_req #(
    parameter int RW = 17,
    parameter int SW = 8
) (
    // requesting side
    input wire logic a_clk,
    input wire logic a_rst,
    input wire logic a_valid,
    input wire logic [RW-1:0] a_data,
    output logic a_busy,
    output logic a_done,
    output logic [SW-1:0] a_rsp,
    // serving side
    input wire logic b_clk,
    input wire logic b_rst,
    output logic b_valid,
    output logic [RW-1:0] b_data,
    input wire logic b_rsp_valid,
    input wire logic [SW-1:0] b_rsp
);
    typedef struct packed {
        logic req_tgl;
        logic busy;
        logic ack_s1;
        logic ack_s2;
        logic ack_seen;
        logic done;
        logic [RW-1:0] data;
        logic [SW-1:0] rsp;
    } sfrb_cdca_s;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic valid;
        logic ack_tgl;
        logic [RW-1:0] data;
        logic [SW-1:0] rsp;
    } sfrb_cdcb_s;

    sfrb_cdca_s aq;
    sfrb_cdca_s ad;
    sfrb_cdcb_s bq;
    sfrb_cdcb_s bd;

    // payload is held still while busy, so the far side may sample it freely
    always_comb
    begin
        ad = aq;
        ad.done = 1'b0;
        ad.ack_s1 = bq.ack_tgl;
        ad.ack_s2 = aq.ack_s1;
        if (aq.ack_s2 != aq.ack_seen)
        begin
            ad.ack_seen = aq.ack_s2;
            ad.busy = 1'b0;
            ad.done = 1'b1;
            ad.rsp = bq.rsp;
        end
        else if (!aq.busy && a_valid)
        begin
            ad.data = a_data;
            ad.req_tgl = ~aq.req_tgl;
            ad.busy = 1'b1;
        end
    end

    always_comb
    begin
        bd = bq;
        bd.valid = 1'b0;
        bd.req_s1 = aq.req_tgl;
        bd.req_s2 = bq.req_s1;
        if (bq.req_s2 != bq.req_seen)
        begin
            bd.req_seen = bq.req_s2;
            bd.data = aq.data;
            bd.valid = 1'b1;
        end
        if (b_rsp_valid)
        begin
            bd.rsp = b_rsp;
            bd.ack_tgl = ~bq.ack_tgl;
        end
    end

    always_ff @(posedge a_clk)
    begin
        if (a_rst)
        begin
            aq <= '0;
        end
        else
        begin
            aq <= ad;
        end
    end

    always_ff @(posedge b_clk)
    begin
        if (b_rst)
        begin
            bq <= '0;
        end
        else
        begin
            bq <= bd;
        end
    end

    assign a_busy = aq.busy;
    assign a_done = aq.done;
    assign a_rsp = aq.rsp;
    assign b_valid = bq.valid;
    assign b_data = bq.data;
endmodule : sfrb_cdc_req
`default_nettype wire

//--- hw/sfrb_status_flags.sv
// What this block does
// - status registers ignore writes entirely
// - low bit 0 mirrors LDO supply comparator
// - bits 1,2 set on junction over-temperature
// - bits 3,4 set on thermal recovery
// - bits 5,6 set on thermistor hot/cold
// - bit 7 set on converter over-current
// - low flags latch on onset until cleared
// - high bit 0 mirrors debounced aux pin
// - high bit 1 latches brownout, cleared at power-up
// - high bit 3 latches over-power
// - high bit 4 latches clamp over-voltage
// - high flags latch on onset until cleared
// - hidden latch catches both aux edges
// - aux pin debounced before use
// - clear registers clear flags written one
// - clear-on-read enable resets to one
// - interrupt low when enabled flag set
`default_nettype none
module sfrb_status_flags
    import sfrb_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = int'(sfrb_pkg::DEBOUNCE_CYCLES)
) (
    // core clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register access from the serial engine, on its own clock
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic link_req,
    input wire logic link_we,
    input wire logic [7:0] link_addr,
    input wire logic [7:0] link_wdata,
    output logic link_busy,
    output logic link_ack,
    output logic [7:0] link_rdata,
    // analog comparator outputs and pin, asynchronous
    input wire logic ldo_supply_cmp,
    input wire logic rect_overtemp_cmp,
    input wire logic conv_overtemp_cmp,
    input wire logic rect_cool_cmp,
    input wire logic conv_cool_cmp,
    input wire logic thermistor_hot_cmp,
    input wire logic thermistor_cold_cmp,
    input wire logic conv_overcurrent_cmp,
    input wire logic brownout_cmp,
    input wire logic overpower_cmp,
    input wire logic clamp_overvoltage_cmp,
    input wire logic aux_input_pin,
    // interrupt and converter limit
    output logic int_n,
    output logic [3:0] current_limit_select
);
    typedef struct packed {
        logic [NUM_IN-1:0] sync1;
        logic [NUM_IN-1:0] sync2;
        logic [NUM_EVT-1:0] prev;
        logic aux_level;
        logic aux_irq;
        logic [7:0] low_flags;
        logic [7:0] high_flags;
        logic [7:0] irq_enable;
        logic [7:0] sys_ctrl;
        logic [7:0] conv_setup;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic int_n;
    } sfrb_core_s;

    sfrb_core_s q;
    sfrb_core_s d;

    logic [NUM_IN-1:0] raw_in;
    logic aux_deb;
    logic req_valid;
    logic [REQ_W-1:0] req_data;
    logic req_we;
    logic [7:0] req_addr;
    logic [7:0] req_wdata;
    logic [NUM_EVT-1:0] onset;
    logic [7:0] set_low;
    logic [7:0] set_high;
    logic [7:0] clr_low;
    logic [7:0] clr_high;
    logic aux_set;
    logic aux_clr;
    logic cor;
    logic [7:0] stat_low;
    logic [7:0] stat_high;
    logic [7:0] rdata;
    logic [7:0] irq_src;

    assign raw_in = {aux_input_pin, clamp_overvoltage_cmp, overpower_cmp, brownout_cmp,
                     conv_overcurrent_cmp, thermistor_cold_cmp, thermistor_hot_cmp,
                     conv_cool_cmp, rect_cool_cmp, conv_overtemp_cmp, rect_overtemp_cmp,
                     ldo_supply_cmp};
    assign {req_we, req_addr, req_wdata} = req_data;

    sfrb_debounce #(
        .CYCLES(DEBOUNCE_CYCLES)
    ) u_debounce (
        .clock(clock),
        .sys_rst(sys_rst),
        .din(q.sync2[IDX_AUX]),
        .dout(aux_deb)
    );

    sfrb_cdc_req #(
        .RW(REQ_W),
        .SW(RSP_W)
    ) u_cdc (
        .a_clk(link_clk),
        .a_rst(link_rst),
        .a_valid(link_req),
        .a_data({link_we, link_addr, link_wdata}),
        .a_busy(link_busy),
        .a_done(link_ack),
        .a_rsp(link_rdata),
        .b_clk(clock),
        .b_rst(sys_rst),
        .b_valid(req_valid),
        .b_data(req_data),
        .b_rsp_valid(q.rsp_valid),
        .b_rsp(q.rsp_data)
    );

    always_comb
    begin
        d = q;
        d.sync1 = raw_in;
        d.sync2 = q.sync1;
        d.prev = q.sync2[NUM_EVT-1:0];
        d.aux_level = aux_deb;
        cor = q.sys_ctrl[SYS_CTRL_COR_BIT];

        // each event counts once at its beginning, however long it lasts
        onset = q.sync2[NUM_EVT-1:0] & ~q.prev;
        set_low = {onset[7:1], 1'b0};
        set_high = 8'h00;
        set_high[HIGH_BROWNOUT_BIT] = onset[IDX_BROWNOUT];
        set_high[HIGH_OVERPOWER_BIT] = onset[IDX_OVERPOWER];
        set_high[HIGH_OVERVOLT_BIT] = onset[IDX_OVERVOLT];
        aux_set = q.aux_level != aux_deb;

        stat_low = (q.low_flags & LOW_LATCH_MASK) | {7'h00, q.sync2[IDX_LDO]};
        stat_high = (q.high_flags & HIGH_LATCH_MASK) | {7'h00, q.aux_level};

        clr_low = 8'h00;
        clr_high = 8'h00;
        aux_clr = 1'b0;
        rdata = 8'h00;
        if (req_valid)
        begin
            case (req_addr)
                ADDR_STAT_LOW:
                begin
                    rdata = stat_low;
                    // only what went out in this byte is cleared
                    if (!req_we && cor)
                    begin
                        clr_low = stat_low & LOW_LATCH_MASK;
                    end
                end
                ADDR_STAT_HIGH:
                begin
                    rdata = stat_high;
                    if (!req_we && cor)
                    begin
                        clr_high = stat_high & HIGH_LATCH_MASK;
                        aux_clr = 1'b1;
                    end
                end
                ADDR_CLR_LOW:
                begin
                    if (req_we)
                    begin
                        clr_low = req_wdata & LOW_LATCH_MASK;
                    end
                end
                ADDR_CLR_HIGH:
                begin
                    if (req_we)
                    begin
                        clr_high = req_wdata & HIGH_LATCH_MASK;
                        aux_clr = req_wdata[AUX_CLR_BIT];
                    end
                end
                ADDR_IRQ_ENABLE:
                begin
                    rdata = q.irq_enable;
                    if (req_we)
                    begin
                        d.irq_enable = req_wdata;
                    end
                end
                ADDR_SYS_CTRL:
                begin
                    rdata = q.sys_ctrl;
                    if (req_we)
                    begin
                        d.sys_ctrl = req_wdata;
                    end
                end
                ADDR_CONV_SETUP:
                begin
                    rdata = q.conv_setup;
                    if (req_we)
                    begin
                        d.conv_setup = req_wdata;
                    end
                end
                default:
                begin
                    rdata = 8'h00;
                end
            endcase
        end

        // writes to the status offsets fall through with no effect
        // a new event in the clearing cycle survives: set beats clear
        d.low_flags = ((q.low_flags & ~clr_low) | set_low) & LOW_LATCH_MASK;
        d.high_flags = ((q.high_flags & ~clr_high) | set_high) & HIGH_LATCH_MASK;
        d.aux_irq = (q.aux_irq & ~aux_clr) | aux_set;

        d.rsp_valid = req_valid;
        d.rsp_data = rdata;

        irq_src = {q.aux_irq,
                   q.high_flags[HIGH_OVERVOLT_BIT],
                   q.high_flags[HIGH_OVERPOWER_BIT],
                   q.low_flags[7],
                   q.low_flags[6],
                   q.low_flags[5],
                   q.low_flags[2] | q.low_flags[4],
                   q.low_flags[1] | q.low_flags[3]};
        d.int_n = ~|(irq_src & q.irq_enable);
    end

    // flags start clear, but prev also resets low, so a brownout held from power-up still latches as an onset
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            q <= '0;
            q.low_flags <= FLAGS_RST;
            q.high_flags <= FLAGS_RST;
            q.irq_enable <= IRQ_ENABLE_RST;
            q.sys_ctrl <= SYS_CTRL_RST;
            q.conv_setup <= CONV_SETUP_RST;
            q.int_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign int_n = q.int_n;
    assign current_limit_select = q.conv_setup[CUR_LIMIT_LSB +: CUR_LIMIT_W];
endmodule : sfrb_status_flags
`default_nettype wire

//--- verif/sfrb_assertions.sv
`default_nettype none
module sfrb_checker #(
    parameter int DEBOUNCE_CYCLES = 16
) (
    // core side
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic int_n,
    input wire logic [3:0] current_limit_select,
    // link side
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic link_req,
    input wire logic link_busy,
    input wire logic link_ack,
    input wire logic [7:0] link_rdata
);
    chk_ack_single: assert property (@(posedge link_clk) disable iff (link_rst)
        link_ack |=> !link_ack) else $error("ack longer than one cycle");
    chk_req_taken: assert property (@(posedge link_clk) disable iff (link_rst)
        link_req && !link_busy && !link_ack |=> link_busy) else $error("request not taken");
    chk_ack_bound: assert property (@(posedge link_clk) disable iff (link_rst)
        $rose(link_busy) |-> ##[1:8] link_ack) else $error("no ack in time");
    chk_busy_ack: assert property (@(posedge link_clk) disable iff (link_rst)
        link_ack |-> !link_busy) else $error("busy during ack");
    chk_ack_cause: assert property (@(posedge link_clk) disable iff (link_rst)
        $rose(link_ack) |-> $past(link_busy)) else $error("ack without request");
    chk_rdata_hold: assert property (@(posedge link_clk) disable iff (link_rst)
        !link_ack |-> $stable(link_rdata)) else $error("read data moved without ack");
    // limit only moves while a register write is in flight
    chk_limit_write: assert property (@(posedge clock) disable iff (sys_rst)
        $changed(current_limit_select) |-> link_busy) else $error("limit changed idle");
    // flags and latches only clear through an access, so int release needs one
    chk_int_release: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(int_n) |-> link_busy) else $error("interrupt released idle");
    cov_read_data: cover property (@(posedge link_clk) disable iff (link_rst)
        link_ack && link_rdata != 8'h00);
    cov_int: cover property (@(posedge clock) disable iff (sys_rst) $fell(int_n));
    cov_limit: cover property (@(posedge clock) disable iff (sys_rst)
        $changed(current_limit_select));
endmodule : sfrb_checker

bind sfrb_status_flags sfrb_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) sfrb_checker_i (
    .clock(clock), .sys_rst(sys_rst), .int_n(int_n),
    .current_limit_select(current_limit_select), .link_clk(link_clk),
    .link_rst(link_rst), .link_req(link_req), .link_busy(link_busy),
    .link_ack(link_ack), .link_rdata(link_rdata));
`default_nettype wire

//--- verif/sfrb_host_model.sv
`default_nettype none
module sfrb_host_model (
    // link clock
    input wire logic link_clk,
    // request toward the block
    output logic link_req,
    output logic link_we,
    output logic [7:0] link_addr,
    output logic [7:0] link_wdata,
    // answer from the block
    input wire logic link_busy,
    input wire logic link_ack,
    input wire logic [7:0] link_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle cycles before each request, raised to act as a slow host
    int gap = 0;
    int timeouts = 0;

    initial
    begin
        link_req = 1'b0;
        link_we = 1'b0;
        link_addr = 8'h00;
        link_wdata = 8'h00;
    end

    task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] wd,
                        output logic [7:0] rd);
        int n;
        repeat (gap) @(posedge link_clk);
        @(posedge link_clk);
        while (link_busy !== 1'b0)
            @(posedge link_clk);
        #1;
        link_req = 1'b1;
        link_we = we;
        link_addr = a;
        link_wdata = wd;
        @(posedge link_clk);
        #1;
        link_req = 1'b0;
        @(posedge link_clk);
        n = 1;
        while (link_ack !== 1'b1 && n < 20)
        begin
            @(posedge link_clk);
            n++;
        end
        if (link_ack !== 1'b1)
            timeouts++;
        rd = link_rdata;
        #1;
        // released lines show the inverse, never a stale copy
        link_we = ~we;
        link_addr = ~a;
        link_wdata = ~wd;
    endtask : xfer

    // both status bytes back to back, low byte first, then the high byte
    task automatic rd_pair(output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        xfer(1'b0, 8'h00, 8'h00, lo);
        xfer(1'b0, 8'h01, 8'h00, hi);
        v = {hi, lo};
    endtask : rd_pair
endmodule : sfrb_host_model
`default_nettype wire

//--- verif/sfrb_status_flags_test.sv
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("mismatch %s exp %h got %h", nm, e, g); \
        end \
    end
module sfrb_status_flags_test
    import sfrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DB = 16;
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic link_rst = 1'b1;
    logic aux = 1'b0;
    logic [10:0] cmp = '0;
    logic link_req, link_we, link_busy, link_ack, int_n;
    logic [7:0] link_addr, link_wdata, link_rdata;
    logic [3:0] cur_lim;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;

    initial
    begin
        forever #2 clock = ~clock;
    end
    initial
    begin
        #7.3;
        forever #62.5 link_clk = ~link_clk;
    end

    sfrb_status_flags #(.DEBOUNCE_CYCLES(DB)) sfrb_status_flags_i (
        .clock(clock), .sys_rst(sys_rst), .link_clk(link_clk), .link_rst(link_rst),
        .link_req(link_req), .link_we(link_we), .link_addr(link_addr),
        .link_wdata(link_wdata), .link_busy(link_busy), .link_ack(link_ack),
        .link_rdata(link_rdata), .ldo_supply_cmp(cmp[0]), .rect_overtemp_cmp(cmp[1]),
        .conv_overtemp_cmp(cmp[2]), .rect_cool_cmp(cmp[3]), .conv_cool_cmp(cmp[4]),
        .thermistor_hot_cmp(cmp[5]), .thermistor_cold_cmp(cmp[6]),
        .conv_overcurrent_cmp(cmp[7]), .brownout_cmp(cmp[8]), .overpower_cmp(cmp[9]),
        .clamp_overvoltage_cmp(cmp[10]), .aux_input_pin(aux), .int_n(int_n),
        .current_limit_select(cur_lim));

    sfrb_host_model host_i (
        .link_clk(link_clk), .link_req(link_req), .link_we(link_we),
        .link_addr(link_addr), .link_wdata(link_wdata), .link_busy(link_busy),
        .link_ack(link_ack), .link_rdata(link_rdata));

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        host_i.xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] r;
        host_i.xfer(1'b0, a, 8'h00, r);
        `CHK(nm, e, r)
    endtask : rchk

    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    initial
    begin
        logic [15:0] pr;
        logic [7:0] a;
        logic [7:0] e;
        tick(6);
        sys_rst = 1'b0;
        repeat (2) @(posedge link_clk);
        #1;
        link_rst = 1'b0;
        host_i.rd_pair(pr);
        `CHK("power_up", 16'h0000, pr)
        rchk(ADDR_SYS_CTRL, SYS_CTRL_RST, "sys_ctrl");
        rchk(ADDR_IRQ_ENABLE, IRQ_ENABLE_RST, "irq_en");
        `CHK("lim_rst", 4'hB, cur_lim)
        // inputs stay high through both reads: one onset, one latch
        for (int k = 1; k < 11; k++)
        begin
            a = (k < 8) ? ADDR_STAT_LOW : ADDR_STAT_HIGH;
            e = (k < 8) ? 8'h01 << k : (k == 8) ? 8'h02 : (k == 9) ? 8'h08 : 8'h10;
            cmp[k] = 1'b1;
            tick(10);
            rchk(a, e, "event");
            rchk(a, 8'h00, "cor");
            cmp[k] = 1'b0;
        end
        cmp[0] = 1'b1;
        tick(10);
        rchk(ADDR_STAT_LOW, 8'h01, "ldo");
        rchk(ADDR_STAT_LOW, 8'h01, "ldo_kept");
        cmp[0] = 1'b0;
        tick(10);
        rchk(ADDR_STAT_LOW, 8'h00, "ldo_low");
        wr(ADDR_SYS_CTRL, 8'h00);
        host_i.gap = 3;
        cmp = 11'h522;
        tick(10);
        cmp = '0;
        wr(ADDR_STAT_LOW, 8'h00);
        wr(ADDR_STAT_HIGH, 8'h00);
        rchk(ADDR_STAT_LOW, 8'h22, "keep_low");
        rchk(ADDR_STAT_HIGH, 8'h12, "keep_high");
        wr(ADDR_CLR_LOW, 8'h02);
        wr(ADDR_CLR_HIGH, 8'h10);
        rchk(ADDR_STAT_LOW, 8'h20, "w1c_low");
        rchk(ADDR_STAT_HIGH, 8'h02, "w1c_high");
        wr(ADDR_CLR_LOW, 8'hFE);
        wr(ADDR_CLR_HIGH, 8'h1F);
        rchk(ADDR_STAT_LOW, 8'h00, "clr_low");
        rchk(ADDR_STAT_HIGH, 8'h00, "clr_high");
        rchk(8'h7E, 8'h00, "unmapped");
        host_i.gap = 0;
        wr(ADDR_IRQ_ENABLE, 8'h01);
        cmp[1] = 1'b1;
        tick(10);
        cmp[1] = 1'b0;
        `CHK("int_on", 1'b0, int_n)
        wr(ADDR_IRQ_ENABLE, 8'h00);
        `CHK("int_mask", 1'b1, int_n)
        wr(ADDR_IRQ_ENABLE, 8'h01);
        `CHK("int_unmask", 1'b0, int_n)
        wr(ADDR_CLR_LOW, 8'h02);
        `CHK("int_clr", 1'b1, int_n)
        wr(ADDR_IRQ_ENABLE, 8'h80);
        aux = 1'b1;
        tick(DB / 2);
        aux = 1'b0;
        tick(40);
        `CHK("glitch", 1'b1, int_n)
        aux = 1'b1;
        tick(DB + 10);
        `CHK("aux_rise", 1'b0, int_n)
        cmp[10:8] = 3'b111;
        tick(10);
        cmp[10:8] = 3'b000;
        rchk(ADDR_STAT_HIGH, 8'h1B, "high_all");
        wr(ADDR_SYS_CTRL, 8'h80);
        rchk(ADDR_STAT_HIGH, 8'h1B, "high_cor");
        `CHK("aux_cor", 1'b1, int_n)
        rchk(ADDR_STAT_HIGH, 8'h01, "aux_level");
        aux = 1'b0;
        tick(DB + 10);
        `CHK("aux_fall", 1'b0, int_n)
        wr(ADDR_CLR_HIGH, 8'h01);
        `CHK("aux_clr", 1'b1, int_n)
        rchk(ADDR_STAT_HIGH, 8'h00, "aux_low");
        // clearing read of one byte must leave the other byte's flags alone
        cmp[1] = 1'b1;
        cmp[9] = 1'b1;
        tick(10);
        cmp = '0;
        rchk(ADDR_CLR_HIGH, 8'h00, "clr_reg_read");
        rchk(ADDR_STAT_LOW, 8'h02, "cor_low");
        rchk(ADDR_STAT_HIGH, 8'h08, "cor_high_kept");
        rchk(ADDR_STAT_LOW, 8'h00, "cor_low_gone");
        rchk(ADDR_STAT_HIGH, 8'h00, "cor_high_gone");
        wr(ADDR_CONV_SETUP, 8'hA5);
        `CHK("lim", 4'h5, cur_lim)
        rchk(ADDR_CONV_SETUP, 8'hA5, "conv");
        `CHK("timeouts", 0, host_i.timeouts)
        end_of_test();
    end
endmodule : sfrb_status_flags_test
`default_nettype wire
